// ---- verilog/cpu8_regs.svh ----
`ifndef CPU8_REGS_SVH
`define CPU8_REGS_SVH
`define REG_A      3'h0
`define REG_B      3'h1
`define REG_C      3'h2
`define REG_D      3'h3
`define REG_E      3'h4
`define REG_H      3'h5
`define REG_L      3'h6
`define REG_MEM    3'h6
`define PAIR_BC    2'h0
`define PAIR_DE    2'h1
`define PAIR_HL    2'h2
`define PAIR_SP    2'h3
`define OP_STORE_IMM    8'h36
`define OP_LOAD_DIRECT  8'h3a
`define OP_STORE_DIRECT 8'h32
`define OP_LOAD_HL_DIR  8'h2a
`define OP_STORE_HL_DIR 8'h22
`define OP_SWAP         8'heb
`define OP_SP_FROM_HL   8'hf9
`define OP_SUM_IMM      8'hc6
`define OP_SUM_CY_IMM   8'hce
`define OP_DIFF_IMM     8'hd6
`define STATES_COPY     5'h05
`define STATES_SHORT    5'h04
`define STATES_TWO      5'h07
`define STATES_THREE    5'h0a
`define STATES_FOUR     5'h0d
`define STATES_FIVE     5'h10
`define FLAG_RESET      5'h00
`endif

// ---- verilog/cpu8_pkg.sv ----
package cpu8_pkg;
  typedef enum logic [1:0] {
    bus_fetch,
    bus_read,
    bus_write
  } bus_kind_t;
  typedef enum logic [1:0] {
    alu_add,
    alu_adc,
    alu_sub
  } alu_op_t;
  typedef struct packed {
    logic zero;
    logic sign;
    logic parity;
    logic carry_flag;
    logic half_carry_flag;
  } flags_t;
endpackage

// ---- verilog/cpu8_alu_if.sv ----
`timescale 1ns/1ps
interface cpu8_alu_if;
  import cpu8_pkg::*;
  alu_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] result;
  flags_t     flags;
  modport core (output op, a, b, cin, input result, flags);
  modport alu  (input op, a, b, cin, output result, flags);
endinterface

// ---- verilog/cpu8_alu.sv ----
`timescale 1ns/1ps
module cpu8_alu (
  cpu8_alu_if.alu port_alu
);
  import cpu8_pkg::*;
  wire       sub_mode = (port_alu.op == alu_sub);
  wire       cin_used = (port_alu.op == alu_adc) ? port_alu.cin : 1'b0;
  wire [7:0] b_eff    = sub_mode ? ~port_alu.b : port_alu.b;
  wire       c0       = sub_mode ? 1'b1 : cin_used;
  wire [4:0] low_sum  = {1'b0, port_alu.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c0};
  wire [8:0] full_sum = {1'b0, port_alu.a} + {1'b0, b_eff} + {8'h00, c0};
  assign port_alu.result                = full_sum[7:0];
  assign port_alu.flags.zero            = (full_sum[7:0] == 8'h00);
  assign port_alu.flags.sign            = full_sum[7];
  assign port_alu.flags.parity          = ~^full_sum[7:0];
  assign port_alu.flags.carry_flag      = full_sum[8] ^ sub_mode;
  assign port_alu.flags.half_carry_flag = low_sum[4];
endmodule

// ---- verilog/cpu8_move_arith_exec.sv ----
`timescale 1ns/1ps
`include "cpu8_regs.svh"
module cpu8_move_arith_exec (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        mem_rdata,
  output logic [15:0]            mem_addr,
  output logic [7:0]             mem_wdata,
  output logic                   mem_read,
  output logic                   mem_write,
  output cpu8_pkg::bus_kind_t    mem_kind,
  output logic [7:0]             acc,
  output logic [15:0]            stack_pointer,
  output logic [15:0]            prog_counter,
  output cpu8_pkg::flags_t       flags,
  output logic [15:0]            reg_bc,
  output logic [15:0]            reg_de,
  output logic [15:0]            reg_hl,
  output logic                   instr_done,
  output logic [4:0]             instr_states,
  output logic [2:0]             instr_cycles,
  output logic                   bad_opcode
);
  import cpu8_pkg::*;

  typedef enum logic [2:0] {
    st_fetch,
    st_decode,
    st_byte2,
    st_byte3,
    st_data1,
    st_data2
  } state_t;

  state_t     state;
  logic [7:0] regs [0:7];
  logic [7:0] opcode;
  logic [7:0] lo_byte;
  logic [15:0] addr_work;
  logic [4:0] states_cnt;
  logic [2:0] cycles_cnt;
  cpu8_alu_if alu_bus ();

  cpu8_alu u_alu (
    .port_alu (alu_bus)
  );

  // register field decode
  function automatic logic [7:0] read_reg(input logic [2:0] code);
    read_reg = regs[code];
  endfunction

  // pair field decode to 16-bit value
  function automatic logic [15:0] read_pair(input logic [1:0] pair);
    case (pair)
      `PAIR_BC: read_pair = {regs[`REG_B], regs[`REG_C]};
      `PAIR_DE: read_pair = {regs[`REG_D], regs[`REG_E]};
      `PAIR_HL: read_pair = {regs[`REG_H], regs[`REG_L]};
      default:  read_pair = stack_pointer;
    endcase
  endfunction

  // register codes follow the fixed decode: 000 A, 001 B ... 110 is memory
  wire [2:0] dest_reg_field    = opcode[5:3];
  wire [2:0] src_reg_field     = opcode[2:0];
  wire [1:0] register_pair_field = opcode[5:4];
  wire       src_is_mem        = (src_reg_field == `REG_MEM);
  wire       dest_is_mem       = (dest_reg_field == `REG_MEM);
  wire [15:0] hl_addr          = {regs[`REG_H], regs[`REG_L]};
  wire [7:0] new_op            = mem_rdata;

  wire is_copy      = (opcode[7:6] == 2'b01) && !(dest_is_mem && src_is_mem);
  wire is_imm_byte  = (opcode[7:6] == 2'b00) && (opcode[2:0] == 3'b110);
  wire is_pair_imm  = (opcode[7:6] == 2'b00) && (opcode[3:0] == 4'h1);
  wire is_via_pair  = (opcode[7:6] == 2'b00) && (opcode[2:0] == 3'b010) && !opcode[5];
  wire is_arith_reg = (opcode[7:6] == 2'b10) && (opcode[5:3] == 3'b000 || opcode[5:3] == 3'b001 ||
                      opcode[5:3] == 3'b010);
  wire is_arith_imm = (opcode == `OP_SUM_IMM) || (opcode == `OP_SUM_CY_IMM) || (opcode == `OP_DIFF_IMM);
  wire is_direct    = (opcode == `OP_LOAD_DIRECT) || (opcode == `OP_STORE_DIRECT) ||
                      (opcode == `OP_LOAD_HL_DIR) || (opcode == `OP_STORE_HL_DIR);

  // mapping of register codes to array slots: code 000 (A) goes to slot 7, other codes use their own index, slot 6 is L
  wire [2:0] dst_slot = (dest_reg_field == 3'h0) ? 3'h7 : dest_reg_field;
  wire [2:0] src_slot = (src_reg_field == 3'h0) ? 3'h7 : src_reg_field;

  assign alu_bus.op  = (opcode[7:3] == 5'b10001 || opcode == `OP_SUM_CY_IMM) ? alu_adc :
                       (opcode[7:3] == 5'b10010 || opcode == `OP_DIFF_IMM) ? alu_sub : alu_add;
  assign alu_bus.a   = acc;
  assign alu_bus.cin = flags.carry_flag;
  assign alu_bus.b   = (state == st_decode) ? regs[src_slot] : mem_rdata;

  assign reg_bc = {regs[`REG_B], regs[`REG_C]};
  assign reg_de = {regs[`REG_D], regs[`REG_E]};
  assign reg_hl = hl_addr;
  assign acc    = regs[7];

  // bus request per state
  always_comb begin
    mem_read  = 1'b0;
    mem_write = 1'b0;
    mem_kind  = bus_fetch;
    mem_addr  = prog_counter;
    mem_wdata = 8'h00;
    case (state)
      st_fetch, st_byte2, st_byte3: begin
        mem_read = 1'b1;
      end
      st_data1: begin
        if (opcode == `OP_LOAD_DIRECT || opcode == `OP_LOAD_HL_DIR) begin
          mem_addr = addr_work;
          mem_read = 1'b1;
          mem_kind = bus_read;
        end else if (opcode == `OP_STORE_DIRECT || opcode == `OP_STORE_HL_DIR) begin
          mem_addr  = addr_work;
          mem_write = 1'b1;
          mem_kind  = bus_write;
          mem_wdata = (opcode == `OP_STORE_DIRECT) ? acc : regs[`REG_L];
        end else if (is_via_pair) begin
          mem_addr  = read_pair(register_pair_field);
          mem_read  = opcode[3];
          mem_write = !opcode[3];
          mem_kind  = opcode[3] ? bus_read : bus_write;
          mem_wdata = acc;
        end else if (opcode == `OP_STORE_IMM) begin
          mem_addr  = hl_addr;
          mem_write = 1'b1;
          mem_kind  = bus_write;
          mem_wdata = lo_byte;
        end else if (dest_is_mem) begin
          mem_addr  = hl_addr;
          mem_write = 1'b1;
          mem_kind  = bus_write;
          mem_wdata = read_reg(src_slot);
        end else begin
          mem_addr = hl_addr;
          mem_read = 1'b1;
          mem_kind = bus_read;
        end
      end
      st_data2: begin
        mem_addr  = addr_work + 16'h0001;
        mem_read  = (opcode == `OP_LOAD_HL_DIR);
        mem_write = (opcode == `OP_STORE_HL_DIR);
        mem_kind  = mem_write ? bus_write : bus_read;
        mem_wdata = regs[`REG_H];
      end
      default: begin
        mem_read = 1'b0;
      end
    endcase
    if (state == st_byte2 || state == st_byte3) begin
      mem_kind = bus_read;
    end
  end

  task automatic finish(input logic [4:0] st, input logic [2:0] cy);
    state        <= st_fetch;
    instr_done   <= 1'b1;
    instr_states <= st;
    instr_cycles <= cy;
  endtask

  always_ff @(posedge clk) begin
    instr_done <= 1'b0;
    if (reset) begin
      state         <= st_fetch;
      opcode        <= 8'h00;
      lo_byte       <= 8'h00;
      addr_work     <= 16'h0000;
      prog_counter  <= 16'h0000;
      stack_pointer <= 16'h0000;
      flags         <= `FLAG_RESET;
      instr_states  <= 5'h00;
      instr_cycles  <= 3'h0;
      bad_opcode    <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      case (state)
        st_fetch: begin
          opcode       <= new_op;
          prog_counter <= prog_counter + 16'h0001;
          state        <= st_decode;
        end
        st_decode: begin
          bad_opcode <= 1'b0;
          if (opcode == `OP_SWAP) begin
            regs[`REG_D] <= regs[`REG_H];
            regs[`REG_E] <= regs[`REG_L];
            regs[`REG_H] <= regs[`REG_D];
            regs[`REG_L] <= regs[`REG_E];
            finish(`STATES_SHORT, 3'h1);
          end else if (opcode == `OP_SP_FROM_HL) begin
            stack_pointer <= hl_addr;
            finish(`STATES_COPY, 3'h1);
          end else if (is_copy && !src_is_mem && !dest_is_mem) begin
            regs[dst_slot] <= read_reg(src_slot);
            finish(`STATES_COPY, 3'h1);
          end else if (is_arith_reg && !src_is_mem) begin
            regs[7] <= alu_bus.result;
            flags   <= alu_bus.flags;
            finish(`STATES_SHORT, 3'h1);
          end else if (is_copy || is_arith_reg || is_via_pair) begin
            state <= st_data1;
          end else if (is_imm_byte || is_pair_imm || is_direct || is_arith_imm) begin
            state <= st_byte2;
          end else begin
            bad_opcode <= 1'b1;
            state      <= st_fetch;
          end
        end
        st_byte2: begin
          prog_counter <= prog_counter + 16'h0001;
          lo_byte      <= mem_rdata;
          if (is_arith_imm) begin
            regs[7] <= alu_bus.result;
            flags   <= alu_bus.flags;
            finish(`STATES_TWO, 3'h2);
          end else if (opcode == `OP_STORE_IMM) begin
            state <= st_data1;
          end else if (is_imm_byte) begin
            regs[dst_slot] <= mem_rdata;
            finish(`STATES_TWO, 3'h2);
          end else begin
            state <= st_byte3;
          end
        end
        st_byte3: begin
          prog_counter <= prog_counter + 16'h0001;
          if (is_pair_imm) begin
            case (register_pair_field)
              `PAIR_BC: {regs[`REG_B], regs[`REG_C]} <= {mem_rdata, lo_byte};
              `PAIR_DE: {regs[`REG_D], regs[`REG_E]} <= {mem_rdata, lo_byte};
              `PAIR_HL: {regs[`REG_H], regs[`REG_L]} <= {mem_rdata, lo_byte};
              default: stack_pointer <= {mem_rdata, lo_byte};
            endcase
            finish(`STATES_THREE, 3'h3);
          end else begin
            addr_work <= {mem_rdata, lo_byte};
            state     <= st_data1;
          end
        end
        st_data1: begin
          if (opcode == `OP_LOAD_DIRECT) begin
            regs[7] <= mem_rdata;
            finish(`STATES_FOUR, 3'h4);
          end else if (opcode == `OP_STORE_DIRECT) begin
            finish(`STATES_FOUR, 3'h4);
          end else if (opcode == `OP_LOAD_HL_DIR) begin
            regs[`REG_L] <= mem_rdata;
            state        <= st_data2;
          end else if (opcode == `OP_STORE_HL_DIR) begin
            state <= st_data2;
          end else if (is_via_pair) begin
            if (opcode[3]) begin
              regs[7] <= mem_rdata;
            end
            finish(`STATES_TWO, 3'h2);
          end else if (opcode == `OP_STORE_IMM) begin
            finish(`STATES_THREE, 3'h3);
          end else if (is_arith_reg) begin
            regs[7] <= alu_bus.result;
            flags   <= alu_bus.flags;
            finish(`STATES_TWO, 3'h2);
          end else if (dest_is_mem) begin
            finish(`STATES_TWO, 3'h2);
          end else begin
            regs[dst_slot] <= mem_rdata;
            finish(`STATES_TWO, 3'h2);
          end
        end
        st_data2: begin
          if (opcode == `OP_LOAD_HL_DIR) begin
            regs[`REG_H] <= mem_rdata;
          end
          finish(`STATES_FIVE, 3'h5);
        end
        default: begin
          state <= st_fetch;
        end
      endcase
    end
  end

  // transfers never touch flags
  property p_transfer_keeps_flags;
    @(posedge clk) disable iff (reset)
      (state == st_decode && (is_copy || opcode == `OP_SWAP || opcode == `OP_SP_FROM_HL || is_imm_byte ||
                              is_pair_imm || is_via_pair || is_direct)) |=>
        $stable(flags);
  endproperty
  a_transfer_keeps_flags: assert property (p_transfer_keeps_flags) else $error("flags moved on transfer");

  property p_swap;
    @(posedge clk) disable iff (reset)
      (state == st_decode && opcode == `OP_SWAP) |=> (reg_hl == $past(reg_de)) && (reg_de == $past(reg_hl));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_sp_load;
    @(posedge clk) disable iff (reset)
      (state == st_decode && opcode == `OP_SP_FROM_HL) |=> stack_pointer == $past(reg_hl);
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("stack pointer not from hl");

  property p_zero_flag;
    @(posedge clk) disable iff (reset)
      (state == st_decode && is_arith_reg && !src_is_mem) |=> flags.zero == (acc == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_parity_flag;
    @(posedge clk) disable iff (reset)
      (state == st_decode && is_arith_reg && !src_is_mem) |=> flags.parity == ~^acc;
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity flag wrong");

  property p_sub_borrow;
    @(posedge clk) disable iff (reset)
      (state == st_decode && opcode[7:3] == 5'b10010 && !src_is_mem) |=>
        flags.carry_flag == ($past(acc) < $past(regs[src_slot]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

  property p_copy_states;
    @(posedge clk) disable iff (reset)
      (state == st_decode && is_copy && !src_is_mem && !dest_is_mem) |=>
        instr_done && instr_states == `STATES_COPY && instr_cycles == 3'h1;
  endproperty
  a_copy_states: assert property (p_copy_states) else $error("copy timing wrong");

  property p_hl_direct_load;
    @(posedge clk) disable iff (reset)
      (state == st_byte3 && opcode == `OP_LOAD_HL_DIR) ##1 mem_read ##1 mem_read |=>
        instr_done && instr_states == `STATES_FIVE && regs[`REG_H] == $past(mem_rdata);
  endproperty
  a_hl_direct_load: assert property (p_hl_direct_load) else $error("direct hl load wrong");
endmodule

// ---- test/cpu8_mem_model.sv ----
`timescale 1ns/1ps
module cpu8_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_pat;

  initial begin
    idle_pat = 8'h5a;
  end

  // stores each write cycle, idle pattern toggles every cycle
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
    if (mem_write) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // zero-wait answer, changing junk when no read is in progress
  assign mem_rdata = mem_read ? mem[mem_addr] : idle_pat;
endmodule

// ---- test/tb_cpu8_move_arith_exec.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_cpu8_move_arith_exec;
  import cpu8_pkg::*;
  logic        clk;
  logic        reset;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_read;
  logic        mem_write;
  bus_kind_t   mem_kind;
  logic [7:0]  acc;
  logic [15:0] stack_pointer;
  logic [15:0] prog_counter;
  flags_t      flags;
  logic [15:0] reg_bc;
  logic [15:0] reg_de;
  logic [15:0] reg_hl;
  logic        instr_done;
  logic [4:0]  instr_states;
  logic [2:0]  instr_cycles;
  logic        bad_opcode;
  int          fails;
  int          n_tests;
  logic [7:0]  prog[$];

  cpu8_move_arith_exec i_dut (
    .clk(clk), .reset(reset), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_read(mem_read), .mem_write(mem_write), .mem_kind(mem_kind), .acc(acc),
    .stack_pointer(stack_pointer), .prog_counter(prog_counter), .flags(flags), .reg_bc(reg_bc),
    .reg_de(reg_de), .reg_hl(reg_hl), .instr_done(instr_done), .instr_states(instr_states),
    .instr_cycles(instr_cycles), .bad_opcode(bad_opcode)
  );

  cpu8_mem_model i_mem (
    .clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_read(mem_read),
    .mem_write(mem_write), .mem_rdata(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hold reset, fill memory with a refused opcode, load program at 0
  task automatic start();
    @(negedge clk);
    reset = 1'b1;
    for (int i = 0; i < 65536; i++) begin
      i_mem.mem[i] = 8'h76;
    end
    foreach (prog[i]) begin
      i_mem.mem[i] = prog[i];
    end
  endtask

  task automatic go();
    repeat (8) @(negedge clk);
    reset = 1'b0;
  endtask

  // wait for retire, then compare documented counts
  task automatic step(input int st, input int cy);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 30) begin
        fails++;
        $display("ERROR t=%0t got=%h exp=%h", $time, instr_done, 1'b1);
        complete_run();
      end
    end while (instr_done !== 1'b1);
    if (st != 0) begin
      `CHK(instr_states, 5'(st));
      `CHK(instr_cycles, 3'(cy));
    end
  endtask

  task automatic fl(input logic z, input logic s, input logic p, input logic c);
    `CHK(flags.zero, z);
    `CHK(flags.sign, s);
    `CHK(flags.parity, p);
    `CHK(flags.carry_flag, c);
  endtask

  task automatic s_transfer();
    prog = '{8'h21, 8'h34, 8'h12, 8'h0e, 8'h5a, 8'h51, 8'h71, 8'h36, 8'hc3, 8'h5e, 8'hf9, 8'heb};
    start();
    go();
    step(10, 3);
    `CHK(reg_hl, 16'h1234);
    step(7, 2);
    `CHK(reg_bc[15:8], 8'h5a);
    step(5, 1);
    `CHK(reg_bc, 16'h5a5a);
    step(7, 2);
    `CHK(i_mem.mem[16'h1234], 8'h5a);
    step(10, 3);
    `CHK(i_mem.mem[16'h1234], 8'hc3);
    step(7, 2);
    `CHK(reg_de[15:8], 8'hc3);
    step(0, 0);
    `CHK(stack_pointer, 16'h1234);
    step(4, 1);
    `CHK(reg_de, 16'h1234);
    `CHK(reg_hl, 16'hc300);
    fl(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic s_direct();
    prog = '{8'h06, 8'h77, 8'hd6, 8'h78, 8'h21, 8'hab, 8'h89, 8'h32, 8'h00, 8'h20, 8'h22, 8'h10,
             8'h20, 8'h3a, 8'h01, 8'h20, 8'h2a, 8'h20, 8'h20, 8'h11, 8'h00, 8'h21, 8'h12, 8'h11,
             8'h01, 8'h21, 8'h1a};
    start();
    i_mem.mem[16'h2001] = 8'h81;
    i_mem.mem[16'h2020] = 8'h11;
    i_mem.mem[16'h2021] = 8'h22;
    i_mem.mem[16'h2101] = 8'h3c;
    go();
    step(7, 2);
    step(7, 2);
    `CHK(acc, 8'hff);
    fl(1'b0, 1'b1, 1'b1, 1'b1);
    step(10, 3);
    step(13, 4);
    `CHK(i_mem.mem[16'h2000], 8'hff);
    step(16, 5);
    `CHK(i_mem.mem[16'h2010], 8'hab);
    `CHK(i_mem.mem[16'h2011], 8'h89);
    step(13, 4);
    `CHK(acc, 8'h81);
    step(16, 5);
    `CHK(reg_hl, 16'h2211);
    step(10, 3);
    step(7, 2);
    `CHK(i_mem.mem[16'h2100], 8'h81);
    step(10, 3);
    step(7, 2);
    `CHK(acc, 8'h3c);
    fl(1'b0, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic s_arith();
    logic [7:0] opc [9] = '{8'h81, 8'h8a, 8'h93, 8'h86, 8'hc6, 8'hce, 8'hd6, 8'h96, 8'h8e};
    logic [7:0] opd [9] = '{8'h88, 8'hef, 8'h01, 8'h01, 8'h7f, 8'h80, 8'hff, 8'h01, 8'h01};
    int         knd [9] = '{0, 1, 2, 0, 0, 1, 2, 2, 1};
    logic [7:0] a;
    logic       c;
    logic       cin;
    logic [8:0] r9;
    logic [4:0] h5;
    prog = '{8'h06, 8'h88, 8'h0e, 8'h88, 8'h16, 8'hef, 8'h1e, 8'h01, 8'h21, 8'h00, 8'h30};
    for (int i = 0; i < 9; i++) begin
      prog.push_back(opc[i]);
      if (opc[i][6]) begin
        prog.push_back(opd[i]);
      end
    end
    start();
    i_mem.mem[16'h3000] = 8'h01;
    go();
    repeat (4) step(7, 2);
    step(10, 3);
    a = 8'h88;
    c = 1'b0;
    for (int i = 0; i < 9; i++) begin
      cin = (knd[i] == 1) ? c : 1'b0;
      r9 = (knd[i] == 2) ? ({1'b0, a} - {1'b0, opd[i]}) : ({1'b0, a} + {1'b0, opd[i]} + 9'(cin));
      h5 = {1'b0, a[3:0]} + {1'b0, opd[i][3:0]} + 5'(cin);
      if (opc[i][6] || opc[i][2:0] == 3'h6) begin
        step(7, 2);
      end else begin
        step(4, 1);
      end
      `CHK(acc, r9[7:0]);
      fl(r9[7:0] == 8'h00, r9[7], ~^r9[7:0], r9[8]);
      if (knd[i] != 2) begin
        `CHK(flags.half_carry_flag, h5[4]);
      end
      a = r9[7:0];
      c = r9[8];
    end
  endtask

  task automatic s_refuse();
    int   n;
    logic seen;
    prog = '{8'h76, 8'h0e, 8'h42, 8'h31, 8'hcd, 8'hab};
    start();
    go();
    `CHK(mem_kind, bus_fetch);
    n = 0;
    seen = 1'b0;
    while (reg_bc[15:8] !== 8'h42 && n < 30) begin
      @(negedge clk);
      if (bad_opcode === 1'b1) begin
        seen = 1'b1;
        `CHK(acc, 8'h00);
      end
      n++;
    end
    `CHK(seen, 1'b1);
    `CHK(reg_bc[15:8], 8'h42);
    `CHK(prog_counter, 16'h0003);
    `CHK(i_mem.mem[16'h0000], 8'h76);
    step(10, 3);
    `CHK(stack_pointer, 16'habcd);
  endtask

  initial begin
    reset = 1'b1;
    fails = 0;
    n_tests = 0;
    s_transfer();
    s_direct();
    s_arith();
    s_refuse();
    complete_run();
  end
endmodule
